// >>> tb/board_model.sv
// board circuitry around the three bidirectional ports
module board_model (
    input wire logic [7:0] a_out_in,
    input wire logic [7:0] a_oe_in,
    input wire logic [7:0] b_out_in,
    input wire logic [7:0] b_oe_in,
    input wire logic [7:0] b_pull_in,
    input wire logic [7:0] c_out_in,
    input wire logic [7:0] c_oe_in,
    input wire logic [7:0] ext_a_in,
    input wire logic [7:0] ext_b_in,
    input wire logic [7:0] ext_b_en_in,
    input wire logic [7:0] ext_c_in,
    output logic [7:0] a_pin_out,
    output logic [7:0] b_pin_out,
    output logic [7:0] c_pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------------
    // board drives a line only where the chip leaves it as input
    assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & ext_a_in);
    assign c_pin_out = (c_oe_in & c_out_in) | (~c_oe_in & ext_c_in);
    // released second-port line goes to the pull-up if fitted, else shows the inverse
    assign b_pin_out = (b_oe_in & b_out_in) | (~b_oe_in & ext_b_en_in & ext_b_in)
        | (~b_oe_in & ~ext_b_en_in & (b_pull_in | ~b_out_in));
endmodule // board_model

// >>> tb/testbench.sv
// self-checking bench for the pin function and port block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] OPT = 8'h0f;
    logic clk = 1'b0, rst_n = 1'b0, osc = 1'b0, irq_n = 1'b1, cap = 1'b0, cmp = 1'b0;
    logic [1:0] dir_we = 2'h0;
    logic [2:0] data_we = 3'h0;
    logic dir_we_c = 1'b0;
    logic [7:0] wdata = 8'h00, ext_a = 8'h00, ext_b = 8'hff, ext_b_en = 8'hff, ext_c = 8'h00;
    logic [7:0] d_pins = 8'h00, a_pin, b_pin, c_pin, a_o, a_oe, b_o, b_oe, b_pull, c_o, c_oe;
    logic [7:0] a_rd, b_rd, c_rd, d_rd;
    logic [1:0] ser;
    logic [3:0] spi;
    logic bus_clk, rst_sync_n, cap_ev, cmp_out, ext_irq, port_irq;
    int error_cnt = 0, num_checks = 0;
    always #20 clk = ~clk;
    pin_block #(.PULL_IRQ_OPT(OPT), .IRQ_MODE(pin_block_pkg::IRQ_EDGE_LEVEL)) pin_block_inst (
        .CORE_CLK_IN(clk), .RSTN_IN(rst_n), .OSC_CLK_IN(osc), .IRQ_N_IN(irq_n),
        .CAPTURE_IN(cap), .COMPARE_LEVEL_IN(cmp), .DIR_WE_IN(dir_we), .DATA_WE_IN(data_we),
        .WDATA_IN(wdata), .DIR_WE_C_IN(dir_we_c), .FIRST_PORT_LINES_IN(a_pin),
        .SECOND_PORT_LINES_IN(b_pin), .THIRD_PORT_LINES_IN(c_pin),
        .INPUT_ONLY_PORT_LINES_IN(d_pins), .BUS_CLK_OUT(bus_clk), .RST_SYNC_N_OUT(rst_sync_n),
        .FIRST_PORT_LINES_OUT(a_o), .FIRST_PORT_OE_OUT(a_oe), .SECOND_PORT_LINES_OUT(b_o),
        .SECOND_PORT_OE_OUT(b_oe), .SECOND_PORT_PULL_OUT(b_pull), .THIRD_PORT_LINES_OUT(c_o),
        .THIRD_PORT_OE_OUT(c_oe), .FIRST_PORT_READ_OUT(a_rd), .SECOND_PORT_READ_OUT(b_rd),
        .THIRD_PORT_READ_OUT(c_rd), .INPUT_ONLY_READ_OUT(d_rd), .ASYNC_SERIAL_UNIT_OUT(ser),
        .SPI_LINES_OUT(spi), .CAPTURE_EVENT_OUT(cap_ev), .COMPARE_OUTPUT_PIN_OUT(cmp_out),
        .EXT_IRQ_OUT(ext_irq), .PORT_IRQ_OUT(port_irq));
    board_model board_model_inst (
        .a_out_in(a_o), .a_oe_in(a_oe), .b_out_in(b_o), .b_oe_in(b_oe), .b_pull_in(b_pull),
        .c_out_in(c_o), .c_oe_in(c_oe), .ext_a_in(ext_a), .ext_b_in(ext_b),
        .ext_b_en_in(ext_b_en), .ext_c_in(ext_c), .a_pin_out(a_pin), .b_pin_out(b_pin),
        .c_pin_out(c_pin));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return cap_ev;
            1: return ext_irq;
            default: return port_irq;
        endcase
    endfunction
    // counts cycles in which the chosen output is high within a bounded window
    task automatic count_high(input int sel, input int n, output int hits);
        hits = 0;
        repeat (n) begin
            @(negedge clk);
            if (pick(sel) === 1'b1) hits++;
        end
    endtask
    // one pulse on a write strobe: 0,1 dir of first/second, 2 dir third, 3..5 data
    task automatic write(input int which, input logic [7:0] val);
        @(negedge clk);
        wdata = val;
        if (which < 2) dir_we[which] = 1'b1;
        else if (which == 2) dir_we_c = 1'b1;
        else data_we[which-3] = 1'b1;
        @(negedge clk);
        dir_we = 2'h0;
        dir_we_c = 1'b0;
        data_we = 3'h0;
        repeat (3) @(negedge clk);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check(a_oe, 8'h00, "first oe in reset");
        check(b_oe, 8'h00, "second oe in reset");
        check(c_oe, 8'h00, "third oe in reset");
        check({7'h00, rst_sync_n}, 8'h00, "sync reset low");
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(a_oe | b_oe | c_oe, 8'h00, "all lines inputs after reset");
        check({7'h00, rst_sync_n}, 8'h01, "sync reset released");
        check(b_pull, OPT, "pull option");
        $display("test reset done");
    endtask
    task automatic t_dirs;
        ext_a = 8'h3c;
        ext_c = 8'hc3;
        write(3, 8'ha5);
        write(0, 8'h0f);
        check(a_oe, 8'h0f, "first oe");
        check(a_rd, 8'h35, "first read mix");
        check(a_o, 8'ha5, "first output latch");
        write(5, 8'h81);
        write(2, 8'hff);
        check(c_oe, 8'hff, "third oe");
        check(c_rd, 8'h81, "third read latch");
        check(c_o, 8'h81, "third output latch");
        write(4, 8'h00);
        write(1, 8'hf0);
        check(b_oe, 8'hf0, "second oe");
        check(b_rd, 8'h0f, "second read");
        check(b_o, 8'h00, "second output latch");
        write(1, 8'h00);
        ext_b_en = 8'h00;
        repeat (3) @(negedge clk);
        check(b_rd & OPT, OPT, "pulled lines read high");
        ext_b_en = 8'hff;
        $display("test direction done");
    endtask
    task automatic t_input_only;
        logic [7:0] v;
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'hff : ((i == 1) ? 8'h96 : 8'h69);
            @(negedge clk);
            d_pins = v;
            repeat (3) @(negedge clk);
            check(d_rd, v & 8'hbf, "input-only read");
            check({6'h00, ser}, {6'h00, v[1:0]}, "async serial lines");
            check({4'h0, spi}, {4'h0, v[5:2]}, "spi lines");
        end
        $display("test input-only done");
    endtask
    task automatic t_bus_clk;
        int rises;
        logic prev;
        rises = 0;
        prev = bus_clk;
        for (int k = 0; k < 64; k++) begin
            @(negedge clk);
            if (k % 4 == 0) osc = ~osc;
            if (bus_clk === 1'b1 && prev === 1'b0) rises++;
            prev = bus_clk;
        end
        // 8 oscillator periods give 4 bus clock periods
        check(8'(rises), 8'h04, "bus clock rate");
        $display("test bus clock done");
    endtask
    task automatic t_timer_irq;
        int h;
        cap = 1'b1;
        count_high(0, 6, h);
        check(8'(h), 8'h01, "capture rise");
        cap = 1'b0;
        count_high(0, 6, h);
        check(8'(h), 8'h01, "capture fall");
        cmp = 1'b1;
        repeat (3) @(negedge clk);
        check({7'h00, cmp_out}, 8'h01, "compare level");
        cmp = 1'b0;
        repeat (3) @(negedge clk);
        check({7'h00, cmp_out}, 8'h00, "compare low");
        irq_n = 1'b0;
        count_high(1, 12, h);
        // edge plus level keeps the request up while the pin is low
        check(8'(h > 8), 8'h01, "irq level");
        irq_n = 1'b1;
        repeat (3) @(negedge clk);
        count_high(1, 6, h);
        check(8'(h), 8'h00, "irq idle");
        ext_b = 8'hfe;
        count_high(2, 8, h);
        check(8'(h), 8'h01, "port irq enabled line");
        ext_b = 8'h7f;
        count_high(2, 8, h);
        check(8'(h), 8'h00, "port irq plain line");
        $display("test timer and irq done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        t_reset();
        t_dirs();
        t_input_only();
        t_bus_clk();
        t_timer_irq();
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check(a_oe | c_oe, 8'h00, "second reset clears direction");
        finish_test();
    end
endmodule // testbench

// >>> verilog/bidir_port.sv
// one bidirectional 8-bit port with direction register and optional pull-ups
module bidir_port #(
    parameter int WIDTH = pin_block_pkg::PORT_WIDTH,
    parameter logic [pin_block_pkg::PORT_WIDTH-1:0] PULL_OPT = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic dir_we_in,
    input wire logic [WIDTH-1:0] dir_wdata_in,
    input wire logic data_we_in,
    input wire logic [WIDTH-1:0] data_wdata_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_out,
    output logic [WIDTH-1:0] pull_en_out,
    output logic [WIDTH-1:0] read_out
);
    // the pull option and reset constants are sized for the 8-line port only
    if (WIDTH != pin_block_pkg::PORT_WIDTH) begin : g_bad_width
        $error("port width must be 8");
    end

    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] pin_val;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_q <= pin_block_pkg::DIR_RESET;
            data_q <= pin_block_pkg::DATA_RESET;
        end else begin
            if (dir_we_in) dir_q <= dir_wdata_in;
            if (data_we_in) data_q <= data_wdata_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // output lines read back the latch, inputs read the pin
            assign pin_val[i] = dir_q[i] ? data_q[i] : pin_in[i];
        end
    endgenerate

    assign pin_out = data_q;
    assign pin_oe_out = dir_q;
    assign pull_en_out = PULL_OPT;
    assign read_out = pin_val;

    chk_driver_follows_dir: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(dir_q[0]) |-> pin_oe_out[0] && $past(dir_we_in))
        else $error("driver enabled without a direction write");
endmodule // bidir_port

// >>> verilog/pin_block.sv
// pin-level top: bus clock, reset, timer pins, irq and four ports
module pin_block #(
    parameter logic [7:0] PULL_IRQ_OPT = 8'h00,
    parameter logic IRQ_MODE = pin_block_pkg::IRQ_EDGE_ONLY
) (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic OSC_CLK_IN,
    input wire logic IRQ_N_IN,
    input wire logic CAPTURE_IN,
    input wire logic COMPARE_LEVEL_IN,
    input wire logic [1:0] DIR_WE_IN,
    input wire logic [2:0] DATA_WE_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic DIR_WE_C_IN,
    input wire logic [7:0] FIRST_PORT_LINES_IN,
    input wire logic [7:0] SECOND_PORT_LINES_IN,
    input wire logic [7:0] THIRD_PORT_LINES_IN,
    input wire logic [7:0] INPUT_ONLY_PORT_LINES_IN,
    output logic BUS_CLK_OUT,
    output logic RST_SYNC_N_OUT,
    output logic [7:0] FIRST_PORT_LINES_OUT,
    output logic [7:0] FIRST_PORT_OE_OUT,
    output logic [7:0] SECOND_PORT_LINES_OUT,
    output logic [7:0] SECOND_PORT_OE_OUT,
    output logic [7:0] SECOND_PORT_PULL_OUT,
    output logic [7:0] THIRD_PORT_LINES_OUT,
    output logic [7:0] THIRD_PORT_OE_OUT,
    output logic [7:0] FIRST_PORT_READ_OUT,
    output logic [7:0] SECOND_PORT_READ_OUT,
    output logic [7:0] THIRD_PORT_READ_OUT,
    output logic [7:0] INPUT_ONLY_READ_OUT,
    output logic [1:0] ASYNC_SERIAL_UNIT_OUT,
    output logic [3:0] SPI_LINES_OUT,
    output logic CAPTURE_EVENT_OUT,
    output logic COMPARE_OUTPUT_PIN_OUT,
    output logic EXT_IRQ_OUT,
    output logic PORT_IRQ_OUT
);
    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire rst_n = rst_sync_q;

    // ------------------------------------------------------------------
    // bus clock divider
    // ------------------------------------------------------------------
    // oscillator sampled as a synchronous input; must be slower than half the core clock
    logic osc_q;
    logic bus_clk_q;
    wire osc_rise = OSC_CLK_IN && !osc_q;

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
            bus_clk_q <= 1'b0;
        end else begin
            osc_q <= OSC_CLK_IN;
            if (osc_rise) bus_clk_q <= !bus_clk_q;
        end
    end

    // ------------------------------------------------------------------
    // bidirectional ports
    // ------------------------------------------------------------------
    logic [7:0] a_pin;
    logic [7:0] a_oe;
    logic [7:0] a_rd;
    logic [7:0] b_pin;
    logic [7:0] b_oe;
    logic [7:0] b_pull;
    logic [7:0] b_rd;
    logic [7:0] c_pin;
    logic [7:0] c_oe;
    logic [7:0] c_rd;

    bidir_port u_first (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(rst_n),
        .dir_we_in(DIR_WE_IN[0]),
        .dir_wdata_in(WDATA_IN),
        .data_we_in(DATA_WE_IN[0]),
        .data_wdata_in(WDATA_IN),
        .pin_in(FIRST_PORT_LINES_IN),
        .pin_out(a_pin),
        .pin_oe_out(a_oe),
        .pull_en_out(),
        .read_out(a_rd)
    );

    bidir_port #(.PULL_OPT(PULL_IRQ_OPT)) u_second (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(rst_n),
        .dir_we_in(DIR_WE_IN[1]),
        .dir_wdata_in(WDATA_IN),
        .data_we_in(DATA_WE_IN[1]),
        .data_wdata_in(WDATA_IN),
        .pin_in(SECOND_PORT_LINES_IN),
        .pin_out(b_pin),
        .pin_oe_out(b_oe),
        .pull_en_out(b_pull),
        .read_out(b_rd)
    );

    bidir_port u_third (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(rst_n),
        .dir_we_in(DIR_WE_C_IN),
        .dir_wdata_in(WDATA_IN),
        .data_we_in(DATA_WE_IN[2]),
        .data_wdata_in(WDATA_IN),
        .pin_in(THIRD_PORT_LINES_IN),
        .pin_out(c_pin),
        .pin_oe_out(c_oe),
        .pull_en_out(),
        .read_out(c_rd)
    );

    // ------------------------------------------------------------------
    // second port interrupt: only lines whose option also gives a pull-up
    // ------------------------------------------------------------------
    logic [7:0] b_prev_q;
    wire [7:0] b_fall = b_prev_q & ~b_rd & PULL_IRQ_OPT;
    wire port_irq_d = |b_fall;

    // ------------------------------------------------------------------
    // input-only port, timer pins, external interrupt
    // ------------------------------------------------------------------
    wire [7:0] d_val = INPUT_ONLY_PORT_LINES_IN & pin_block_pkg::IN_ONLY_MASK;
    logic cap_prev_q;
    logic irq_prev_q;
    wire cap_edge = CAPTURE_IN ^ cap_prev_q;
    wire irq_fall = irq_prev_q && !IRQ_N_IN;
    // level mode keeps the request up while the pin stays low
    wire irq_level = (IRQ_MODE == pin_block_pkg::IRQ_EDGE_LEVEL) && !IRQ_N_IN;
    wire ext_irq_d = irq_fall || irq_level;

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            b_prev_q <= 8'hff;
            cap_prev_q <= 1'b0;
            irq_prev_q <= 1'b1;
        end else begin
            b_prev_q <= b_rd;
            cap_prev_q <= CAPTURE_IN;
            irq_prev_q <= IRQ_N_IN;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            FIRST_PORT_LINES_OUT <= 8'h00;
            FIRST_PORT_OE_OUT <= 8'h00;
            SECOND_PORT_LINES_OUT <= 8'h00;
            SECOND_PORT_OE_OUT <= 8'h00;
            SECOND_PORT_PULL_OUT <= 8'h00;
            THIRD_PORT_LINES_OUT <= 8'h00;
            THIRD_PORT_OE_OUT <= 8'h00;
            FIRST_PORT_READ_OUT <= 8'h00;
            SECOND_PORT_READ_OUT <= 8'h00;
            THIRD_PORT_READ_OUT <= 8'h00;
            INPUT_ONLY_READ_OUT <= 8'h00;
            ASYNC_SERIAL_UNIT_OUT <= 2'h0;
            SPI_LINES_OUT <= 4'h0;
            CAPTURE_EVENT_OUT <= 1'b0;
            COMPARE_OUTPUT_PIN_OUT <= 1'b0;
            EXT_IRQ_OUT <= 1'b0;
            PORT_IRQ_OUT <= 1'b0;
        end else begin
            FIRST_PORT_LINES_OUT <= a_pin;
            FIRST_PORT_OE_OUT <= a_oe;
            SECOND_PORT_LINES_OUT <= b_pin;
            SECOND_PORT_OE_OUT <= b_oe;
            SECOND_PORT_PULL_OUT <= b_pull;
            THIRD_PORT_LINES_OUT <= c_pin;
            THIRD_PORT_OE_OUT <= c_oe;
            FIRST_PORT_READ_OUT <= a_rd;
            SECOND_PORT_READ_OUT <= b_rd;
            THIRD_PORT_READ_OUT <= c_rd;
            INPUT_ONLY_READ_OUT <= d_val;
            ASYNC_SERIAL_UNIT_OUT <= d_val[pin_block_pkg::ASYNC_TX_BIT:pin_block_pkg::ASYNC_RX_BIT];
            SPI_LINES_OUT <= d_val[pin_block_pkg::SPI_HI_BIT:pin_block_pkg::SPI_LO_BIT];
            CAPTURE_EVENT_OUT <= cap_edge;
            COMPARE_OUTPUT_PIN_OUT <= COMPARE_LEVEL_IN;
            EXT_IRQ_OUT <= ext_irq_d;
            PORT_IRQ_OUT <= port_irq_d;
        end
    end

    assign BUS_CLK_OUT = bus_clk_q;
    assign RST_SYNC_N_OUT = rst_sync_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_osc_two_rises;
        osc_rise ##1 (!osc_rise)[*1] ##0 1'b1;
    endsequence

    chk_bus_clk_half: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        osc_rise |=> BUS_CLK_OUT != $past(BUS_CLK_OUT))
        else $error("bus clock did not toggle on oscillator rise");
    chk_bus_clk_hold: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        !osc_rise |=> $stable(BUS_CLK_OUT))
        else $error("bus clock toggled without oscillator rise");
    chk_reset_hold: assert property (@(posedge CORE_CLK_IN)
        !RSTN_IN |=> !RST_SYNC_N_OUT && FIRST_PORT_OE_OUT == 8'h00)
        else $error("startup state not held during reset");
    chk_oe_after_reset: assert property (@(posedge CORE_CLK_IN)
        $rose(rst_n) |-> FIRST_PORT_OE_OUT == 8'h00 && SECOND_PORT_OE_OUT == 8'h00
        && THIRD_PORT_OE_OUT == 8'h00)
        else $error("port not all inputs after reset");
    chk_oe_write: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        DIR_WE_IN[1] |-> ##2 SECOND_PORT_OE_OUT == $past(WDATA_IN, 2))
        else $error("second port direction write lost");
    chk_pull_irq_pair: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        PORT_IRQ_OUT |-> ($past(b_fall) & ~SECOND_PORT_PULL_OUT) == 8'h00 || $past(!rst_n))
        else $error("interrupt on line without pull-up option");
    chk_third_oe: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        DIR_WE_C_IN |-> ##2 THIRD_PORT_OE_OUT == $past(WDATA_IN, 2))
        else $error("third port direction write lost");
    chk_bit_six_absent: assert property (@(posedge CORE_CLK_IN)
        !INPUT_ONLY_READ_OUT[6])
        else $error("absent input-only bit reads high");
    chk_spi_share: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        ##1 SPI_LINES_OUT == INPUT_ONLY_READ_OUT[5:2])
        else $error("spi lines do not follow shared port bits");
    chk_capture_edge: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        $changed(CAPTURE_IN) && $past(rst_n) |=> CAPTURE_EVENT_OUT)
        else $error("capture transition missed");
    chk_compare_pin: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        1'b1 |=> COMPARE_OUTPUT_PIN_OUT == $past(COMPARE_LEVEL_IN))
        else $error("compare pin does not follow timer");
    chk_irq_fall: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        $fell(IRQ_N_IN) && $past(rst_n) |=> EXT_IRQ_OUT)
        else $error("falling irq edge missed");
    chk_irq_level: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
        !IRQ_N_IN && !$fell(IRQ_N_IN) |=> EXT_IRQ_OUT == (IRQ_MODE == 1'b1))
        else $error("level sensitivity does not match option");
endmodule // pin_block

// >>> verilog/pin_block_pkg.sv
// shared constants for the pin function and port block
package pin_block_pkg;
    // ------------------------------------------------------------------
    // widths and bus clock divide ratio
    // ------------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam int IN_ONLY_WIDTH = 8;
    localparam int CLK_DIV = 2;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // bit six of the input-only port is absent
    localparam logic [7:0] IN_ONLY_MASK = 8'hbf;
    // ------------------------------------------------------------------
    // shared line positions on the input-only port
    // ------------------------------------------------------------------
    localparam int ASYNC_RX_BIT = 0;
    localparam int ASYNC_TX_BIT = 1;
    localparam int SPI_LO_BIT = 2;
    localparam int SPI_HI_BIT = 5;
    // ------------------------------------------------------------------
    // interrupt sensitivity options
    // ------------------------------------------------------------------
    localparam logic IRQ_EDGE_ONLY = 1'b0;
    localparam logic IRQ_EDGE_LEVEL = 1'b1;
endpackage
